// >>> rtl/eifed_top.sv
// Overview of operation
// - address trap gives reset or trap interrupt
// - trap interrupt ignores global enable and nesting
// - six inputs, each with noise rejector
// - pin zero is port unless function bit
// - pin zero falling edge only, gated
// - inputs zero, five reject 2 periods
// - input one rejects 63 or 15 periods
// - inputs two to four reject 7 periods
// - slow mode rejects under one slow period
// - inputs one to three: 0 rise, 1 fall
// - input four rise, fall, both, high
// - latch set within settle plus six periods
// - noise time change effective within 26 periods
// - high level needs a rise after reset
// - acceptance clears source latch and global enable
`include "eifed_cfg.svh"
module eifed_top #(
	parameter int LOW_FREQ_DIV = `EIFED_LF_DIV
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// external pins, bit i is ext_irq_zero .. ext_irq_five
	input wire logic [5:0] ext_irq_pin,
	// cpu side
	input wire logic fetch_violation,
	input wire logic irq_ack,
	input wire logic [2:0] irq_ack_src,
	// outputs
	output logic irq,
	output logic fetch_trap_irq,
	output logic trap_reset_req,
	output logic port_zero_bit_zero
);

	if (LOW_FREQ_DIV < 2 || LOW_FREQ_DIV > 65535) begin : g_bad_div
		$error("eifed_top: LOW_FREQ_DIV out of range");
	end

	eifed_pkg::eifed_ext_ctl_t ext_ctl;
	eifed_pkg::eifed_core_t core;
	logic [6:0] enable, sw_clear, ack_clear;
	logic [5:0] latch, sync1, sync2, filt, prev, rise, fall, trig, wr_idx, rd_idx;
	logic [5:0] reject [`EIFED_NUM_SRC];
	logic [2:0] startup_cnt;
	logic [15:0] lf_cnt;
	logic [31:0] wr_data;
	logic trap_latch, load, armed, seen_rise4, lf_tick, tick, do_write, wr_ok;

	// ----------------------------------------
	// pin synchronisers and startup
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
		end else begin
			sync1 <= ext_irq_pin;
			sync2 <= sync1;
		end
	end

	// filters load the pin level after reset: a pin already high is no rise
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			startup_cnt <= 3'h0;
			armed <= 1'b0;
		end else begin
			if (load) begin
				startup_cnt <= startup_cnt + 3'h1;
			end
			armed <= ~load;
		end
	end
	assign load = (startup_cnt != `EIFED_STARTUP);

	// ----------------------------------------
	// low_freq_clock tick divider
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lf_cnt <= 16'h0000;
			lf_tick <= 1'b0;
		end else if (lf_cnt == 16'(LOW_FREQ_DIV - 1)) begin
			lf_cnt <= 16'h0000;
			lf_tick <= 1'b1;
		end else begin
			lf_cnt <= lf_cnt + 16'h0001;
			lf_tick <= 1'b0;
		end
	end
	assign tick = core.low_speed_mode ? lf_tick : 1'b1;

	// ----------------------------------------
	// noise rejectors
	// ----------------------------------------
	// thresholds are combinational, so a new noise time applies at once
	always_comb begin
		for (int i = 0; i < `EIFED_NUM_SRC; i++) begin
			reject[i] = `EIFED_REJ_MID_FC;
		end
		reject[0] = `EIFED_REJ_EDGE_FC;
		reject[5] = `EIFED_REJ_EDGE_FC;
		reject[1] = ext_ctl.noise_time_select ? `EIFED_REJ_ONE_SHORT_FC :
			`EIFED_REJ_ONE_LONG_FC;
		if (core.low_speed_mode) begin
			for (int i = 0; i < `EIFED_NUM_SRC; i++) begin
				reject[i] = `EIFED_REJ_SLOW_FS;
			end
		end
	end

	for (genvar g = 0; g < `EIFED_NUM_SRC; g++) begin : g_filt
		eifed_filter u_filter (
			.core_clk(core_clk), .rst_n(rst_n), .tick(tick), .load(load),
			.reject_len(reject[g]), .level_in(sync2[g]), .level_out(filt[g])
		);
	end

	// ----------------------------------------
	// edge and level detection
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 6'h00;
			seen_rise4 <= 1'b0;
		end else begin
			prev <= filt;
			if (rise[4]) begin
				seen_rise4 <= 1'b1;
			end
		end
	end
	assign rise = filt & ~prev & {6{armed}};
	assign fall = ~filt & prev & {6{armed}};
	always_comb begin
		trig[0] = fall[0] & ext_ctl.pin_function_select;
		trig[1] = ext_ctl.irq_one_edge_select ? fall[1] : rise[1];
		trig[2] = ext_ctl.irq_two_edge_select ? fall[2] : rise[2];
		trig[3] = ext_ctl.irq_three_edge_select ? fall[3] : rise[3];
		case (ext_ctl.irq_four_trigger_select)
			eifed_pkg::EIFED_TRIG_RISE: trig[4] = rise[4];
			eifed_pkg::EIFED_TRIG_FALL: trig[4] = fall[4];
			eifed_pkg::EIFED_TRIG_BOTH: trig[4] = rise[4] | fall[4];
			eifed_pkg::EIFED_TRIG_HIGH: trig[4] = filt[4] & seen_rise4 & armed;
			default: trig[4] = 1'b0;
		endcase
		trig[5] = fall[5];
	end

	// ----------------------------------------
	// latches, set wins over clear
	// ----------------------------------------
	assign sw_clear = (do_write && wr_ok && wr_idx == `EIFED_IDX_CLEAR) ? wr_data[6:0] : 7'h00;
	assign ack_clear = (irq_ack && irq_ack_src <= 3'h6) ? 7'(7'h01 << irq_ack_src) : 7'h00;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch <= 6'h00;
		end else begin
			latch <= (latch & ~sw_clear[5:0] & ~ack_clear[5:0]) | trig;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trap_latch <= 1'b0;
			trap_reset_req <= 1'b0;
		end else begin
			trap_reset_req <= fetch_violation & core.trap_reset_select;
			if (fetch_violation && !core.trap_reset_select) begin
				trap_latch <= 1'b1;
			end else if (sw_clear[`EIFED_TRAP_BIT] || ack_clear[`EIFED_TRAP_BIT]) begin
				trap_latch <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
			fetch_trap_irq <= 1'b0;
			port_zero_bit_zero <= 1'b0;
		end else begin
			irq <= core.global_irq_enable & |(latch & enable[5:0]);
			// the trap bypasses the global enable so it can preempt any service
			fetch_trap_irq <= trap_latch & enable[`EIFED_TRAP_BIT];
			port_zero_bit_zero <= sync2[0];
		end
	end

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	assign wr_ok = (wr_idx >= `EIFED_IDX_EXT_CTL) && (wr_idx <= `EIFED_IDX_CORE);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			wr_idx <= 6'h00;
			wr_data <= 32'h00000000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				wr_idx <= s_axi_awaddr[7:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wr_data <= s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// byte lane zero only; a write without it stores zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_ctl <= `EIFED_EXT_CTL_RST;
			enable <= `EIFED_ENABLE_RST;
			core <= `EIFED_CORE_RST;
		end else begin
			if (do_write && wr_idx == `EIFED_IDX_EXT_CTL) begin
				ext_ctl <= {wr_data[7:1], 1'b0};
			end
			if (do_write && wr_idx == `EIFED_IDX_ENABLE) begin
				enable <= wr_data[6:0];
			end
			if (do_write && wr_idx == `EIFED_IDX_CORE) begin
				core <= wr_data[2:0];
			end else if (irq_ack) begin
				core.global_irq_enable <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	assign rd_idx = s_axi_araddr[7:2];
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (rd_idx)
				`EIFED_IDX_EXT_CTL: s_axi_rdata <= {24'h000000, ext_ctl};
				`EIFED_IDX_STATUS: s_axi_rdata <= {25'h0000000, trap_latch, latch};
				`EIFED_IDX_CLEAR: s_axi_rdata <= 32'h00000000;
				`EIFED_IDX_ENABLE: s_axi_rdata <= {25'h0000000, enable};
				`EIFED_IDX_CORE: s_axi_rdata <= {29'h00000000, core};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	trap_reset_path_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		fetch_violation && core.trap_reset_select |=> trap_reset_req && !$rose(trap_latch))
		else $error("trap reset not raised");
	trap_latch_path_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		fetch_violation && !core.trap_reset_select |=> trap_latch && !trap_reset_req)
		else $error("trap latch not set");
	trap_bypass_gie_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		trap_latch && enable[6] && !core.global_irq_enable |=> fetch_trap_irq)
		else $error("trap interrupt blocked by global enable");
	pin_zero_port_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ext_ctl.pin_function_select && !latch[0] |=> !latch[0])
		else $error("port pin set its latch");
	mid_accept_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!load && !core.low_speed_mode && sync2[2] != filt[2])[*7] |=> filt[2] == $past(sync2[2]))
		else $error("filter two did not accept");
	edge_accept_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!load && !core.low_speed_mode && sync2[5] != filt[5])[*2] |=> filt[5] == $past(sync2[5]))
		else $error("filter five did not accept");
	level_needs_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ext_ctl.irq_four_trigger_select == eifed_pkg::EIFED_TRIG_HIGH && !seen_rise4
		&& !latch[4] |=> !latch[4])
		else $error("level request before a rise");
	edge_one_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rise[1] && !ext_ctl.irq_one_edge_select |=> latch[1])
		else $error("rising edge on input one lost");
	ack_clears_gie_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		irq_ack && !(do_write && wr_idx == `EIFED_IDX_CORE) |=> !core.global_irq_enable)
		else $error("global enable kept after acceptance");

endmodule // eifed_top

// >>> rtl/eifed_cfg.svh
`ifndef EIFED_CFG_SVH
`define EIFED_CFG_SVH

// ----------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------
`define EIFED_IDX_EXT_CTL 6'h37
`define EIFED_IDX_STATUS 6'h38
`define EIFED_IDX_CLEAR 6'h39
`define EIFED_IDX_ENABLE 6'h3a
`define EIFED_IDX_CORE 6'h3b

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define EIFED_EXT_CTL_RST 8'h00
`define EIFED_ENABLE_RST 7'h00
`define EIFED_CORE_RST 3'h0
`define EIFED_CORE_GIE 0
`define EIFED_CORE_SLOW 1
`define EIFED_CORE_TRAP_RST 2
`define EIFED_TRAP_BIT 6
`define EIFED_NUM_SRC 6

// ----------------------------------------
// timing, in periods of core_clk (high_freq_clock, 100 MHz)
// ----------------------------------------
`define EIFED_REJ_EDGE_FC 6'd2
`define EIFED_REJ_ONE_LONG_FC 6'd63
`define EIFED_REJ_ONE_SHORT_FC 6'd15
`define EIFED_REJ_MID_FC 6'd7
// in low_freq_clock ticks: a sub-period pulse meets at most one tick
`define EIFED_REJ_SLOW_FS 6'd2
// core_clk cycles per low_freq_clock period (about 32.768 kHz)
`define EIFED_LF_DIV 3052
`define EIFED_STARTUP 3'd4

`endif

// >>> rtl/eifed_pkg.sv
package eifed_pkg;

	// ----------------------------------------
	// control register layout
	// ----------------------------------------
	typedef enum logic [1:0] {
		EIFED_TRIG_RISE = 2'b00,
		EIFED_TRIG_FALL = 2'b01,
		EIFED_TRIG_BOTH = 2'b10,
		EIFED_TRIG_HIGH = 2'b11
	} eifed_trig_t;

	typedef struct packed {
		logic noise_time_select;
		logic pin_function_select;
		eifed_trig_t irq_four_trigger_select;
		logic irq_three_edge_select;
		logic irq_two_edge_select;
		logic irq_one_edge_select;
		logic spare;
	} eifed_ext_ctl_t;

	typedef struct packed {
		logic trap_reset_select;
		logic low_speed_mode;
		logic global_irq_enable;
	} eifed_core_t;

endpackage

// >>> rtl/eifed_filter.sv
module eifed_filter (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// control
	input wire logic tick,
	input wire logic load,
	input wire logic [5:0] reject_len,
	// signal
	input wire logic level_in,
	output logic level_out
);

	logic [5:0] stable_cnt;

	// ----------------------------------------
	// stable-sample counter
	// ----------------------------------------
	// any sample agreeing with the output restarts the count, so a pulse
	// only gets through if it lasts reject_len consecutive samples
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stable_cnt <= 6'h00;
			level_out <= 1'b0;
		end else if (load) begin
			stable_cnt <= 6'h00;
			level_out <= level_in;
		end else if (level_in == level_out) begin
			stable_cnt <= 6'h00;
		end else if (tick) begin
			if (stable_cnt + 6'h01 >= reject_len) begin
				stable_cnt <= 6'h00;
				level_out <= level_in;
			end else begin
				stable_cnt <= stable_cnt + 6'h01;
			end
		end
	end

endmodule // eifed_filter

// >>> tb/eifed_pins.sv
module eifed_pins (
	// clock
	input wire logic core_clk,
	// pins
	output logic [5:0] pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// falling-edge inputs idle high, the others idle low
	initial pin = 6'h21;

	task automatic set(input int ch, input logic v);
		@(posedge core_clk);
		pin[ch] <= v;
	endtask

	task automatic pulse(input int ch, input int len);
		@(posedge core_clk);
		pin[ch] <= ~pin[ch];
		repeat (len) @(posedge core_clk);
		pin[ch] <= ~pin[ch];
	endtask
endmodule // eifed_pins

// >>> tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] CTL = 8'hdc;
	localparam logic [7:0] ST = 8'he0;
	localparam logic [7:0] CLR = 8'he4;
	localparam logic [7:0] EN = 8'he8;
	localparam logic [7:0] CORE = 8'hec;

	logic core_clk, rst_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [5:0] ext_irq_pin;
	logic fetch_violation, irq_ack;
	logic [2:0] irq_ack_src;
	logic irq, fetch_trap_irq, trap_reset_req, port_zero_bit_zero;
	int err_total, n_tests;

	// short divider keeps slow-mode runs brief
	eifed_top #(.LOW_FREQ_DIV(4)) DUT (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ext_irq_pin, .fetch_violation, .irq_ack, .irq_ack_src, .irq, .fetch_trap_irq,
		.trap_reset_req, .port_zero_bit_zero);

	eifed_pins pins (.core_clk(core_clk), .pin(ext_irq_pin));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// a fresh edge first, so no strobe is driven twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, pb;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pb) begin
			@(posedge core_clk);
			if (pb && s_axi_bvalid) begin
				pb = 1'b0;
				s_axi_bready <= 1'b0;
				rd_resp = s_axi_bresp;
			end
			if (pa && s_axi_awready) begin
				pa = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (pw && s_axi_wready) begin
				pw = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a);
		logic pa, pr;
		pa = 1'b1;
		pr = 1'b1;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (pr) begin
			@(posedge core_clk);
			if (pr && s_axi_rvalid) begin
				pr = 1'b0;
				s_axi_rready <= 1'b0;
				rd_data = s_axi_rdata;
				rd_resp = s_axi_rresp;
			end
			if (pa && s_axi_arready) begin
				pa = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
		end
	endtask

	task automatic clr;
		wr(CLR, 32'h7f);
	endtask

	task automatic ack(input int src);
		@(posedge core_clk);
		irq_ack <= 1'b1;
		irq_ack_src <= src[2:0];
		@(posedge core_clk);
		irq_ack <= 1'b0;
	endtask

	task automatic fv;
		@(posedge core_clk);
		fetch_violation <= 1'b1;
		@(posedge core_clk);
		fetch_violation <= 1'b0;
	endtask

	task automatic st_is(input int settle, input logic [31:0] exp);
		w(settle);
		rd(ST);
		chk(rd_data, exp);
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{fetch_violation, irq_ack} = 2'h0;
		irq_ack_src = 3'h0;
		err_total = 0;
		n_tests = 0;
		w(16);
		rst_n <= 1'b1;
		rd(CTL);
		chk(rd_data, 32'h0);
		rd(EN);
		chk(rd_data, 32'h0);
		rd(8'h00);
		chk(rd_resp, 2'b10);
		wr(8'h00, 32'hff);
		chk(rd_resp, 2'b10);
		chk(port_zero_bit_zero, 1'b1);
		// configure before enabling, so a rewrite cannot raise a stray request
		wr(CTL, 32'h40);
		wr(EN, 32'h7f);
		wr(CORE, 32'h1);
		clr();
		for (int ch = 0; ch < 6; ch += 5) begin
			pins.pulse(ch, 1);
			st_is(20, 32'h0);
			pins.pulse(ch, 8);
			st_is(20, 32'h1 << ch);
			chk(irq, 1'b1);
			ack(ch);
			st_is(1, 32'h0);
			rd(CORE);
			chk(rd_data, 32'h0);
			wr(CORE, 32'h1);
		end
		wr(EN, 32'h7e);
		wr(CTL, 32'h0);
		clr();
		pins.pulse(0, 8);
		st_is(20, 32'h0);
		pins.set(0, 1'b0);
		w(4);
		chk(port_zero_bit_zero, 1'b0);
		pins.set(0, 1'b1);
		w(4);
		chk(port_zero_bit_zero, 1'b1);
		wr(EN, 32'h7f);
		for (int m = 0; m < 2; m++) begin
			wr(CTL, m ? 32'hc0 : 32'h40);
			w(26);
			clr();
			pins.pulse(1, m ? 12 : 40);
			st_is(20, 32'h0);
			pins.pulse(1, m ? 20 : 70);
			st_is(20, 32'h2);
		end
		for (int ch = 2; ch < 4; ch++) begin
			wr(CTL, 32'h40 | (32'h1 << ch));
			clr();
			pins.set(ch, 1'b1);
			st_is(30, 32'h0);
			pins.set(ch, 1'b0);
			st_is(30, 32'h1 << ch);
		end
		for (int c = 0; c < 4; c++) begin
			wr(CTL, 32'h40 | (c << 4));
			clr();
			pins.set(4, 1'b1);
			st_is(30, {27'h0, c != 1, 4'h0});
			// level mode relatches while the pin is still high
			clr();
			pins.set(4, 1'b0);
			st_is(30, {27'h0, c != 0, 4'h0});
		end
		pins.set(4, 1'b1);
		@(posedge core_clk);
		rst_n <= 1'b0;
		w(4);
		rst_n <= 1'b1;
		wr(CTL, 32'h70);
		st_is(30, 32'h0);
		pins.set(4, 1'b0);
		w(30);
		pins.set(4, 1'b1);
		st_is(30, 32'h10);
		pins.set(4, 1'b0);
		wr(EN, 32'h7f);
		w(20);
		clr();
		fv();
		w(3);
		chk(fetch_trap_irq, 1'b1);
		chk(irq, 1'b0);
		st_is(1, 32'h40);
		ack(6);
		st_is(1, 32'h0);
		wr(CORE, 32'h4);
		clr();
		fv();
		#1;
		chk(trap_reset_req, 1'b1);
		st_is(3, 32'h0);
		wr(CTL, 32'h40);
		wr(CORE, 32'h2);
		clr();
		pins.pulse(3, 2);
		st_is(60, 32'h0);
		pins.pulse(3, 20);
		st_is(60, 32'h8);
		end_of_test();
	end

	initial begin
		w(20000);
		err_total++;
		end_of_test();
	end
endmodule // testbench
